// File: core/gpio_freeze_seq.sv
/*
 * Three-write key sequence that freezes pin configuration.
 * Assumes write strobes from the register port on the same clock.
 */
`timescale 1ns/10ps
module gpio_freeze_seq (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_sync_n,
    input wire logic clk_en,
    // Freeze register write
    input wire logic wr,
    input wire logic key,
    input wire logic [15:0] mask,
    // Freeze state
    output logic locked,
    output logic [15:0] lock_mask
);
    gpio_pkg::freeze_state_t q, d;

    always_comb begin
        d = q;
        if (wr && !q.locked) begin
            d.mask = mask;
            case (q.st)
                gpio_pkg::FRZ_IDLE: begin
                    d.st = key ? gpio_pkg::FRZ_ONE : gpio_pkg::FRZ_IDLE;
                end
                gpio_pkg::FRZ_ONE: begin
                    if (!key && mask == q.mask) begin
                        d.st = gpio_pkg::FRZ_TWO;
                    end else begin
                        d.st = key ? gpio_pkg::FRZ_ONE : gpio_pkg::FRZ_IDLE;
                    end
                end
                gpio_pkg::FRZ_TWO: begin
                    if (key && mask == q.mask) begin
                        d.locked = 1'b1;
                        d.st = gpio_pkg::FRZ_IDLE;
                    end else begin
                        d.st = key ? gpio_pkg::FRZ_ONE : gpio_pkg::FRZ_IDLE;
                    end
                end
                default: begin
                    d.st = gpio_pkg::FRZ_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            q <= '{st: gpio_pkg::FRZ_IDLE, mask: 16'h0000, locked: 1'b0};
        end else if (clk_en) begin
            q <= d;
        end
    end

    assign locked = q.locked;
    assign lock_mask = q.mask;

endmodule : gpio_freeze_seq

// File: core/gpio_pin_cell.sv
/*
 * Pad control of one pin, decoded from its configuration nibble.
 * Purely combinational; the caller registers the results.
 */
`timescale 1ns/10ps
module gpio_pin_cell (
    // Configuration
    input wire logic [3:0] cfg,
    input wire logic out_bit,
    input wire logic [1:0] pull_ctl,
    input wire logic [3:0] af_sel,
    // Peripheral outputs for this pin
    input wire logic [15:0] af_sig,
    // Pad controls
    output logic drv_out,
    output logic drv_oe,
    output logic drv_pu,
    output logic drv_pd,
    output logic drv_in_en
);
    logic [1:0] mode;
    logic [1:0] cnf;
    logic data;

    always_comb begin
        mode = cfg[1:0];
        cnf = cfg[3:2];
        data = cnf[gpio_pkg::CNF_AF_BIT] ? af_sig[af_sel] : out_bit;
        drv_out = 1'b0;
        drv_oe = 1'b0;
        drv_pu = 1'b0;
        drv_pd = 1'b0;
        drv_in_en = 1'b1;
        if (mode == gpio_pkg::MODE_IN) begin
            if (cnf == gpio_pkg::CNF_ANALOG) begin
                drv_in_en = 1'b0;
            end else if (cnf == gpio_pkg::CNF_PULLED) begin
                drv_pu = out_bit;
                drv_pd = ~out_bit;
            end
        end else if (cnf[gpio_pkg::CNF_OD_BIT]) begin
            drv_oe = ~data;
            drv_pu = pull_ctl[gpio_pkg::PULL_EN_BIT] &
                pull_ctl[gpio_pkg::PULL_UP_BIT];
            drv_pd = pull_ctl[gpio_pkg::PULL_EN_BIT] &
                ~pull_ctl[gpio_pkg::PULL_UP_BIT];
        end else begin
            drv_out = data;
            drv_oe = 1'b1;
        end
    end

endmodule : gpio_pin_cell

// File: core/gpio_pkg.sv
/*
 * Shared constants and types of the 16-pin general-purpose port.
 * Assumes one clock domain and the register access port of gpio_port.
 */
package gpio_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, one aligned word each)
    // ------------------------------------------------------------
    localparam logic [5:0] OFS_CFG_LO = 6'h00;
    localparam logic [5:0] OFS_CFG_HI = 6'h04;
    localparam logic [5:0] OFS_IN = 6'h08;
    localparam logic [5:0] OFS_OUT = 6'h0c;
    localparam logic [5:0] OFS_SET_CLR = 6'h10;
    localparam logic [5:0] OFS_CLR = 6'h14;
    localparam logic [5:0] OFS_FREEZE = 6'h18;
    localparam logic [5:0] OFS_PULL = 6'h1c;
    localparam logic [5:0] OFS_AF_LO = 6'h20;
    localparam logic [5:0] OFS_AF_HI = 6'h24;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] CFG_LO_RST = 32'h4444_4444;
    localparam logic [31:0] CFG_HI_RST_A = 32'h4884_4444;
    localparam logic [31:0] CFG_HI_RST_B = 32'h4444_4444;
    localparam logic [15:0] OUT_RST = 16'h0000;
    localparam logic [31:0] PULL_RST = 32'h0000_0000;
    localparam logic [31:0] AF_RST = 32'h0000_0000;

    // ------------------------------------------------------------
    // Field positions and codes
    // ------------------------------------------------------------
    localparam int unsigned CNF_LSB = 2;
    localparam logic [1:0] MODE_IN = 2'h0;
    localparam logic [1:0] CNF_ANALOG = 2'h0;
    localparam logic [1:0] CNF_PULLED = 2'h2;
    localparam int unsigned CNF_OD_BIT = 0;
    localparam int unsigned CNF_AF_BIT = 1;
    localparam int unsigned PULL_EN_BIT = 0;
    localparam int unsigned PULL_UP_BIT = 1;
    localparam int unsigned SET_CLR_HI_LSB = 16;
    localparam int unsigned FREEZE_KEY_BIT = 16;
    localparam int unsigned DBG_DATA_PIN = 13;
    localparam int unsigned DBG_CLK_PIN = 14;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic vld;
        logic wr;
        logic [5:0] addr;
        logic [3:0] be;
        logic [31:0] wdata;
    } acc_req_t;

    typedef struct packed {
        logic [15:0] out;
        logic [15:0] oe;
        logic [15:0] pu;
        logic [15:0] pd;
        logic [15:0] in_en;
    } pad_drv_t;

    typedef enum logic [2:0] {
        FRZ_IDLE = 3'b001,
        FRZ_ONE = 3'b010,
        FRZ_TWO = 3'b100
    } freeze_st_t;

    typedef struct packed {
        freeze_st_t st;
        logic [15:0] mask;
        logic locked;
    } freeze_state_t;

endpackage : gpio_pkg

// File: core/gpio_port.sv
/*
 * 16-pin general-purpose port: configuration, output latch, input
 * sampling, pulls, alternate functions and configuration freeze.
 * Assumes a synchronous register access port on clk_sys, pad cells that
 * resolve out/oe/pu/pd, and peripheral outputs on the same clock.
 */
`timescale 1ns/10ps
module gpio_port #(
    parameter bit PORT_A = 1'b1
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register access
    input wire gpio_pkg::acc_req_t acc_req,
    output logic [31:0] acc_rdata_q,
    output logic acc_ack_q,
    // Pins
    input wire logic [15:0] pin_in,
    output gpio_pkg::pad_drv_t pad_q,
    // Peripheral side
    input wire logic [15:0][15:0] af_sig,
    output logic [15:0] pin_level_q
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0] cfg_lo;
        logic [31:0] cfg_hi;
        logic [15:0] out_latch;
        logic [31:0] pull_ctl;
        logic [31:0] af_lo;
        logic [31:0] af_hi;
        logic [1:0] dbg_dflt;
        logic [15:0] sync1;
        logic [15:0] sync2;
        logic [15:0] in_sample;
        gpio_pkg::pad_drv_t pad;
        logic [31:0] rdata;
        logic ack;
    } port_state_t;

    port_state_t q, d;
    logic [1:0] rst_sync_q;
    logic rst_sync_n;
    logic [31:0] be_mask;
    logic wr_any;
    logic frz_locked;
    logic [15:0] frz_mask;
    logic frz_wr;
    logic [16:0] frz_wval;
    logic [31:0] cfg_lock_lo;
    logic [31:0] cfg_lock_hi;
    logic [15:0] set_bits;
    logic [15:0] clr_bits;
    logic [15:0] latch_eff;
    logic [63:0] cfg_all;
    logic [63:0] af_all;
    gpio_pkg::pad_drv_t pad_d;

    // ------------------------------------------------------------
    // Reset release
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_sync_q <= 2'h0;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_sync_q[1];

    // ------------------------------------------------------------
    // Access decode
    // ------------------------------------------------------------
    always_comb begin
        for (int b = 0; b < 4; b++) begin
            be_mask[b*8 +: 8] = {8{acc_req.be[b]}};
        end
        wr_any = acc_req.vld & acc_req.wr;
        frz_wr = wr_any & (acc_req.addr == gpio_pkg::OFS_FREEZE);
        frz_wval = ({frz_locked, frz_mask} & ~be_mask[16:0]) |
            (acc_req.wdata[16:0] & be_mask[16:0]);
        set_bits = '0;
        clr_bits = '0;
        if (wr_any && acc_req.addr == gpio_pkg::OFS_SET_CLR) begin
            set_bits = acc_req.wdata[15:0] & be_mask[15:0];
            clr_bits = acc_req.wdata[31:16] & be_mask[31:16];
        end else if (wr_any && acc_req.addr == gpio_pkg::OFS_CLR) begin
            clr_bits = acc_req.wdata[15:0] & be_mask[15:0];
        end
    end

    // ------------------------------------------------------------
    // Configuration freeze
    // ------------------------------------------------------------
    gpio_freeze_seq u_freeze (
        .clk_sys(clk_sys),
        .rst_sync_n(rst_sync_n),
        .clk_en(clk_en),
        .wr(frz_wr),
        .key(frz_wval[gpio_pkg::FREEZE_KEY_BIT]),
        .mask(frz_wval[15:0]),
        .locked(frz_locked),
        .lock_mask(frz_mask)
    );

    always_comb begin
        for (int p = 0; p < 8; p++) begin
            cfg_lock_lo[p*4 +: 4] = {4{frz_locked & frz_mask[p]}};
            cfg_lock_hi[p*4 +: 4] = {4{frz_locked & frz_mask[p+8]}};
        end
    end

    // ------------------------------------------------------------
    // Pad decode per pin
    // ------------------------------------------------------------
    always_comb begin
        latch_eff = q.out_latch;
        if (PORT_A && q.dbg_dflt[0]) begin
            latch_eff[gpio_pkg::DBG_DATA_PIN] = 1'b1;
        end
        if (PORT_A && q.dbg_dflt[1]) begin
            latch_eff[gpio_pkg::DBG_CLK_PIN] = 1'b0;
        end
        cfg_all = {q.cfg_hi, q.cfg_lo};
        af_all = {q.af_hi, q.af_lo};
    end

    for (genvar g = 0; g < 16; g++) begin : g_pin
        gpio_pin_cell u_cell (
            .cfg(cfg_all[g*4 +: 4]),
            .out_bit(latch_eff[g]),
            .pull_ctl(q.pull_ctl[g*2 +: 2]),
            .af_sel(af_all[g*4 +: 4]),
            .af_sig(af_sig[g]),
            .drv_out(pad_d.out[g]),
            .drv_oe(pad_d.oe[g]),
            .drv_pu(pad_d.pu[g]),
            .drv_pd(pad_d.pd[g]),
            .drv_in_en(pad_d.in_en[g])
        );
    end

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d = q;
        d.ack = acc_req.vld;
        d.rdata = 32'h0000_0000;
        // Pin sampling, two stages then the input register
        d.sync1 = pin_in;
        d.sync2 = q.sync1;
        d.in_sample = q.sync2 & q.pad.in_en;
        d.pad = pad_d;
        // Latch update, set applied after clear so set wins
        d.out_latch = (q.out_latch & ~clr_bits) | set_bits;
        if (wr_any) begin
            case (acc_req.addr)
                gpio_pkg::OFS_CFG_LO: begin
                    d.cfg_lo = (q.cfg_lo & ~(be_mask & ~cfg_lock_lo)) |
                        (acc_req.wdata & be_mask & ~cfg_lock_lo);
                end
                gpio_pkg::OFS_CFG_HI: begin
                    d.cfg_hi = (q.cfg_hi & ~(be_mask & ~cfg_lock_hi)) |
                        (acc_req.wdata & be_mask & ~cfg_lock_hi);
                    if (be_mask[gpio_pkg::DBG_DATA_PIN*4 - 32]
                        && !cfg_lock_hi[gpio_pkg::DBG_DATA_PIN*4 - 32]) begin
                        d.dbg_dflt[0] = 1'b0;
                    end
                    if (be_mask[gpio_pkg::DBG_CLK_PIN*4 - 32]
                        && !cfg_lock_hi[gpio_pkg::DBG_CLK_PIN*4 - 32]) begin
                        d.dbg_dflt[1] = 1'b0;
                    end
                end
                gpio_pkg::OFS_OUT: begin
                    d.out_latch = (q.out_latch & ~be_mask[15:0]) |
                        (acc_req.wdata[15:0] & be_mask[15:0]);
                end
                gpio_pkg::OFS_PULL: begin
                    d.pull_ctl = (q.pull_ctl & ~be_mask) |
                        (acc_req.wdata & be_mask);
                end
                gpio_pkg::OFS_AF_LO: begin
                    d.af_lo = (q.af_lo & ~be_mask) |
                        (acc_req.wdata & be_mask);
                end
                gpio_pkg::OFS_AF_HI: begin
                    d.af_hi = (q.af_hi & ~be_mask) |
                        (acc_req.wdata & be_mask);
                end
                default: begin
                end
            endcase
        end
        if (acc_req.vld && !acc_req.wr) begin
            case (acc_req.addr)
                gpio_pkg::OFS_CFG_LO: d.rdata = q.cfg_lo;
                gpio_pkg::OFS_CFG_HI: d.rdata = q.cfg_hi;
                gpio_pkg::OFS_IN: d.rdata = {16'h0000, q.in_sample};
                gpio_pkg::OFS_OUT: d.rdata = {16'h0000, q.out_latch};
                gpio_pkg::OFS_FREEZE: begin
                    d.rdata = {15'h0000, frz_locked, frz_mask};
                end
                gpio_pkg::OFS_PULL: d.rdata = q.pull_ctl;
                gpio_pkg::OFS_AF_LO: d.rdata = q.af_lo;
                gpio_pkg::OFS_AF_HI: d.rdata = q.af_hi;
                default: d.rdata = 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            q.cfg_lo <= gpio_pkg::CFG_LO_RST;
            q.cfg_hi <= PORT_A ? gpio_pkg::CFG_HI_RST_A
                : gpio_pkg::CFG_HI_RST_B;
            q.out_latch <= gpio_pkg::OUT_RST;
            q.pull_ctl <= gpio_pkg::PULL_RST;
            q.af_lo <= gpio_pkg::AF_RST;
            q.af_hi <= gpio_pkg::AF_RST;
            q.dbg_dflt <= 2'h3;
            q.sync1 <= 16'h0000;
            q.sync2 <= 16'h0000;
            q.in_sample <= 16'h0000;
            q.pad <= '{out: 16'h0000, oe: 16'h0000, pu: 16'h0000,
                pd: 16'h0000, in_en: 16'hffff};
            q.rdata <= 32'h0000_0000;
            q.ack <= 1'b0;
        end else if (clk_en) begin
            q <= d;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign acc_rdata_q = q.rdata;
    assign acc_ack_q = q.ack;
    assign pad_q = q.pad;
    assign pin_level_q = q.in_sample;

endmodule : gpio_port

// File: sim/gpio_pin_model.sv
/*
 * Board around the port: resolves each pin from the pad drive,
 * weak pulls and an outside source; undriven pins wander.
 */
`timescale 1ns/10ps
module gpio_pin_model (
    // Clock
    input wire logic clk_sys,
    // Pad controls
    input wire gpio_pkg::pad_drv_t pad_q,
    // Outside source
    input wire logic [15:0] ext_en,
    input wire logic [15:0] ext_val,
    // Pin levels
    output logic [15:0] pin_in
);
    logic [15:0] float_q;

    initial float_q = 16'h5555;
    always @(posedge clk_sys) float_q <= ~float_q;

    always_comb begin
        for (int i = 0; i < 16; i++) begin
            if (pad_q.oe[i]) begin
                pin_in[i] = pad_q.out[i];
            end else if (ext_en[i]) begin
                pin_in[i] = ext_val[i];
            end else if (pad_q.pu[i] || pad_q.pd[i]) begin
                pin_in[i] = pad_q.pu[i];
            end else begin
                pin_in[i] = float_q[i];
            end
        end
    end
endmodule : gpio_pin_model

// File: sim/gpio_port_assertions.sv
/*
 * Checker of the port's access answers, pads and input sampling.
 * Bound to gpio_port; sees only its ports, one clock domain.
 */
`timescale 1ns/10ps
module gpio_port_chk #(
    parameter bit PORT_A = 1'b1
) (
    // Clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic clk_en,
    // Register access
    input wire gpio_pkg::acc_req_t acc_req,
    input wire logic [31:0] acc_rdata_q,
    input wire logic acc_ack_q,
    // Pins
    input wire logic [15:0] pin_in,
    input wire gpio_pkg::pad_drv_t pad_q,
    // Peripheral side
    input wire logic [15:0][15:0] af_sig,
    input wire logic [15:0] pin_level_q
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // ----------
    // Helper state
    // ----------
    logic [3:0] up_q;
    logic [5:0] addr_q;
    logic rd_q;
    logic lk_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            up_q <= 4'h0;
            addr_q <= 6'h00;
            rd_q <= 1'b0;
            lk_q <= 1'b0;
        end else begin
            if (up_q != 4'hf) begin
                up_q <= up_q + 4'h1;
            end
            addr_q <= acc_req.addr;
            rd_q <= acc_req.vld && !acc_req.wr;
            if (acc_ack_q && rd_q && addr_q == gpio_pkg::OFS_FREEZE
                && acc_rdata_q[16]) begin
                lk_q <= 1'b1;
            end
        end
    end

    // ----------
    // Assertions
    // ----------
    ack_follows_req_a:
        assert property ((acc_req.vld && clk_en) |=> acc_ack_q)
        else $error("access not acknowledged");
    no_stray_ack_a:
        assert property (!acc_req.vld |=> !acc_ack_q && acc_rdata_q == 32'h0)
        else $error("answer without request");
    input_read_a:
        assert property (acc_ack_q && rd_q && addr_q == gpio_pkg::OFS_IN
            |-> acc_rdata_q[31:16] == 16'h0 && (acc_rdata_q[15:0] ==
            pin_level_q || acc_rdata_q[15:0] == $past(pin_level_q)))
        else $error("input read differs from sample");
    analog_off_a:
        assert property (((pad_q.oe | pad_q.pu | pad_q.pd) & ~pad_q.in_en)
            == 16'h0)
        else $error("analog pin drives or pulls");
    pulls_apart_a:
        assert property ((pad_q.pu & pad_q.pd) == 16'h0)
        else $error("pull up and down together");
    analog_zero_a:
        assert property ($stable(pad_q.in_en)[*4]
            |-> (pin_level_q & ~pad_q.in_en) == 16'h0)
        else $error("analog pin samples nonzero");
    pin_sample_a:
        assert property ((up_q == 4'hf && clk_en
            && pad_q.in_en == 16'hffff)[*4]
            |-> pin_level_q == $past(pin_in, 3))
        else $error("input sample latency wrong");
    reset_float_a:
        assert property (up_q < 4'h3
            |-> pad_q.oe == 16'h0 && pad_q.in_en == 16'hffff)
        else $error("pins not floating after reset");
    debug_pulls_a:
        assert property (PORT_A && up_q == 4'h6
            |-> pad_q.pu[gpio_pkg::DBG_DATA_PIN]
            && pad_q.pd[gpio_pkg::DBG_CLK_PIN])
        else $error("debug pin pulls missing");
    lock_sticky_a:
        assert property (lk_q && acc_ack_q && rd_q
            && addr_q == gpio_pkg::OFS_FREEZE |-> acc_rdata_q[16])
        else $error("freeze key bit dropped");
endmodule : gpio_port_chk

// File: sim/gpio_port_tb.sv
/*
 * Self-checking bench of the general-purpose port.
 * Drives the access port, outside pin sources and peripheral signals.
 */
`timescale 1ns/10ps
`define CHK(nm, e, a) \
    begin \
        check_count++; \
        if ((a) !== (e)) begin \
            n_errors++; \
            $display("mismatch %s exp %h got %h", nm, e, a); \
        end \
    end
module gpio_port_tb;
    logic clk_sys;
    logic rst_n;
    logic clk_en;
    gpio_pkg::acc_req_t acc_req;
    logic [31:0] acc_rdata_q;
    logic acc_ack_q;
    logic [15:0] pin_in;
    gpio_pkg::pad_drv_t pad_q;
    logic [15:0][15:0] af_sig;
    logic [15:0] pin_level_q;
    logic [15:0] ext_en;
    logic [15:0] ext_val;
    logic [31:0] rd;
    int n_errors;
    int check_count;

    gpio_port #(.PORT_A(1'b1)) u_gpio_port (
        .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
        .acc_req(acc_req), .acc_rdata_q(acc_rdata_q),
        .acc_ack_q(acc_ack_q), .pin_in(pin_in), .pad_q(pad_q),
        .af_sig(af_sig), .pin_level_q(pin_level_q)
    );
    gpio_pin_model u_gpio_pin_model (
        .clk_sys(clk_sys), .pad_q(pad_q), .ext_en(ext_en),
        .ext_val(ext_val), .pin_in(pin_in)
    );

    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end

    // ----------
    // Access tasks
    // ----------
    task automatic acc(input logic w, input logic [5:0] a,
        input logic [3:0] be, input logic [31:0] wd);
        @(posedge clk_sys);
        acc_req <= {1'b1, w, a, be, wd};
        @(posedge clk_sys);
        acc_req.vld <= 1'b0;
        #1;
        `CHK("ack", 1'b1, acc_ack_q)
        rd = acc_rdata_q;
    endtask : acc

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask : wt

    // ----------
    // Scenarios
    // ----------
    task automatic t_reset;
        wt(8);
        `CHK("oe", 16'h0, pad_q.oe)
        `CHK("dbg", 2'b11, {pad_q.pu[13], pad_q.pd[14]})
        acc(0, gpio_pkg::OFS_CFG_HI, 4'hf, 32'h0);
        `CHK("cfg_hi", gpio_pkg::CFG_HI_RST_A, rd)
        acc(0, gpio_pkg::OFS_CFG_LO, 4'hf, 32'h0);
        `CHK("cfg_lo", gpio_pkg::CFG_LO_RST, rd)
    endtask : t_reset

    task automatic t_in;
        @(posedge clk_sys);
        ext_en <= 16'h0001;
        ext_val <= 16'h0001;
        acc(1, gpio_pkg::OFS_CFG_LO, 4'h1, 32'h40);
        wt(6);
        `CHK("an", 4'h0, {pad_q.in_en[0], pad_q.oe[0], pad_q.pu[0], pad_q.pd[0]})
        acc(0, gpio_pkg::OFS_IN, 4'hf, 32'h0);
        `CHK("an_in", 1'b0, rd[0])
        acc(1, gpio_pkg::OFS_CFG_LO, 4'h1, 32'h44);
        wt(6);
        acc(0, gpio_pkg::OFS_IN, 4'hf, 32'h0);
        `CHK("fl_in", 1'b1, rd[0])
        `CHK("fl", 3'b100, {pad_q.in_en[0], pad_q.pu[0], pad_q.pd[0]})
        acc(1, gpio_pkg::OFS_CFG_LO, 4'h1, 32'h48);
        wt(2);
        `CHK("pdn", 3'b001, {pad_q.oe[0], pad_q.pu[0], pad_q.pd[0]})
        acc(1, gpio_pkg::OFS_OUT, 4'h3, 32'h1);
        wt(2);
        `CHK("pup", 3'b010, {pad_q.oe[0], pad_q.pu[0], pad_q.pd[0]})
        @(posedge clk_sys);
        ext_en <= 16'h0;
    endtask : t_in

    task automatic t_out;
        acc(1, gpio_pkg::OFS_CFG_LO, 4'h1, 32'h42);
        wt(2);
        `CHK("pp1", 4'b1100, {pad_q.oe[0], pad_q.out[0], pad_q.pu[0], pad_q.pd[0]})
        acc(1, gpio_pkg::OFS_OUT, 4'h3, 32'h0);
        wt(2);
        `CHK("pp0", 2'b10, {pad_q.oe[0], pad_q.out[0]})
        wt(4);
        acc(0, gpio_pkg::OFS_IN, 4'hf, 32'h0);
        `CHK("pp_in", 1'b0, rd[0])
        acc(0, gpio_pkg::OFS_OUT, 4'hf, 32'h0);
        `CHK("out", 32'h0, rd)
    endtask : t_out

    task automatic t_setclr;
        acc(1, gpio_pkg::OFS_OUT, 4'h3, 32'h00f0);
        acc(1, gpio_pkg::OFS_SET_CLR, 4'hf, 32'h0003_0101);
        acc(1, gpio_pkg::OFS_CLR, 4'h3, 32'h0010);
        acc(1, gpio_pkg::OFS_OUT, 4'h2, 32'h0000_aa00);
        acc(0, gpio_pkg::OFS_OUT, 4'hf, 32'h0);
        `CHK("latch", 32'h0000_aae1, rd)
        @(posedge clk_sys);
        clk_en <= 1'b0;
        acc_req <= {1'b1, 1'b1, gpio_pkg::OFS_OUT, 4'hf, 32'h0};
        @(posedge clk_sys);
        clk_en <= 1'b1;
        acc_req.vld <= 1'b0;
        acc(0, gpio_pkg::OFS_OUT, 4'hf, 32'h0);
        `CHK("latch_frozen", 32'h0000_aae1, rd)
        wt(1);
        `CHK("pin0", 1'b1, pad_q.out[0])
        acc(0, gpio_pkg::OFS_SET_CLR, 4'hf, 32'h0);
        `CHK("bsc_rd", 32'h0, rd)
    endtask : t_setclr

    task automatic t_od;
        acc(1, gpio_pkg::OFS_PULL, 4'h1, 32'h0f);
        acc(1, gpio_pkg::OFS_CFG_LO, 4'h1, 32'h16);
        wt(2);
        `CHK("od1", 3'b010, {pad_q.oe[0], pad_q.pu[0], pad_q.pd[0]})
        `CHK("pp_pull", 2'b00, {pad_q.pu[1], pad_q.pd[1]})
        acc(1, gpio_pkg::OFS_PULL, 4'h1, 32'h01);
        acc(1, gpio_pkg::OFS_OUT, 4'h3, 32'h0);
        wt(2);
        `CHK("od0", 3'b101, {pad_q.oe[0], pad_q.out[0], pad_q.pd[0]})
    endtask : t_od

    task automatic t_af;
        acc(1, gpio_pkg::OFS_PULL, 4'h1, 32'h0);
        acc(1, gpio_pkg::OFS_CFG_LO, 4'h1, 32'h19);
        for (int s = 0; s < 16; s++) begin
            acc(1, gpio_pkg::OFS_AF_LO, 4'h1, {28'h0, 4'(s)});
            @(posedge clk_sys);
            af_sig[0] <= 16'h1 << s;
            wt(3);
            `CHK("af1", 2'b11, {pad_q.oe[0], pad_q.out[0]})
            @(posedge clk_sys);
            af_sig[0] <= ~(16'h1 << s);
            wt(3);
            `CHK("af0", 1'b0, pad_q.out[0])
        end
        acc(1, gpio_pkg::OFS_CFG_LO, 4'h1, 32'h1f);
        @(posedge clk_sys);
        af_sig[0] <= 16'hffff;
        wt(3);
        `CHK("af_od", 1'b0, pad_q.oe[0])
    endtask : t_af

    task automatic t_lock;
        acc(1, gpio_pkg::OFS_FREEZE, 4'hf, 32'h0001_0001);
        acc(1, gpio_pkg::OFS_FREEZE, 4'hf, 32'h0000_0001);
        acc(1, gpio_pkg::OFS_FREEZE, 4'hf, 32'h0001_0001);
        acc(1, gpio_pkg::OFS_FREEZE, 4'hf, 32'h0);
        acc(0, gpio_pkg::OFS_FREEZE, 4'hf, 32'h0);
        `CHK("frz", 32'h0001_0001, rd)
        acc(1, gpio_pkg::OFS_CFG_LO, 4'h1, 32'h44);
        acc(0, gpio_pkg::OFS_CFG_LO, 4'hf, 32'h0);
        `CHK("cfg_lk", 32'h4444_444f, rd)
        acc(1, gpio_pkg::OFS_OUT, 4'h3, 32'h5);
        acc(0, gpio_pkg::OFS_OUT, 4'hf, 32'h0);
        `CHK("out_lk", 32'h5, rd)
        @(posedge clk_sys);
        rst_n <= 1'b0;
        wt(3);
        @(posedge clk_sys);
        rst_n <= 1'b1;
        wt(8);
        acc(0, gpio_pkg::OFS_FREEZE, 4'hf, 32'h0);
        `CHK("frz_rst", 32'h0, rd)
    endtask : t_lock

    task automatic results;
        if (n_errors == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : results

    initial begin
        #40000;
        n_errors++;
        results();
    end

    initial begin
        rst_n = 1'b0;
        clk_en = 1'b1;
        acc_req = '0;
        af_sig = '0;
        ext_en = 16'h0;
        ext_val = 16'h0;
        n_errors = 0;
        check_count = 0;
        repeat (3) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_in();
        t_out();
        t_setclr();
        t_od();
        t_af();
        t_lock();
        results();
    end
endmodule : gpio_port_tb

bind gpio_port gpio_port_chk #(.PORT_A(PORT_A)) u_gpio_port_chk (
    .clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
    .acc_req(acc_req), .acc_rdata_q(acc_rdata_q),
    .acc_ack_q(acc_ack_q), .pin_in(pin_in), .pad_q(pad_q),
    .af_sig(af_sig), .pin_level_q(pin_level_q)
);
